// *** core/vpin_params.svh ***
// Constants for the video input pin-sharing block: register offsets,
// field positions, reset values and timing counts.
// Assumes inclusion by bare name from the core files.
`ifndef VPIN_PARAMS_SVH
`define VPIN_PARAMS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define VP_AW 8
`define VP_OFS_CTRL 8'h00
`define VP_OFS_GPO 8'h04
`define VP_OFS_GPIO 8'h08
`define VP_OFS_STAT 8'h0c
`define VP_OFS_DECNT 8'h10

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define VP_CTRL_W 7
`define VP_CTRL_RST 7'h01
`define VP_CTRL_FILT 0
`define VP_CTRL_EDGE 1
`define VP_CTRL_M18 2
`define VP_CTRL_AUDGPO 3
`define VP_CTRL_DBSEL_LO 4
`define VP_CTRL_DBSEL_HI 5
`define VP_CTRL_B0GPO 6

// ----------------------------------------
// Output and GPIO register fields
// ----------------------------------------
`define VP_GPO_LO 4
`define VP_GPO_HI 8
`define VP_GPO_RST 5'h00
`define VP_GPIO_DIR_LO 0
`define VP_GPIO_DIR_HI 3
`define VP_GPIO_OUT_LO 4
`define VP_GPIO_OUT_HI 7
`define VP_GPIO_RST 4'h0

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define VP_STAT_GPIN_LO 0
`define VP_STAT_GPIN_HI 3
`define VP_STAT_M18 4
`define VP_STAT_STRAP 5
`define VP_STAT_DE 6
`define VP_STAT_ADDR_LO 8
`define VP_STAT_ADDR_HI 14

// ----------------------------------------
// Timing and address strap
// ----------------------------------------
`define VP_DE_MIN_PCLK 3
`define VP_DE_CNT_W 2
`define VP_DECNT_W 16
`define VP_ADDR_BASE 4'h3
`define VP_ADDR_CODE_W 3

`endif

// *** core/vpin_pkg.sv ***
// Types shared by the video input pin-sharing files.
// Assumes the constants header is compiled alongside.
package vpin_pkg;

  // Uses of the shared second audio data pin
  typedef enum logic [1:0] {
    VPIN_DB_AUDIO = 2'h0,
    VPIN_DB_BLUE1 = 2'h1,
    VPIN_DB_GPO5 = 2'h3
  } vpin_db_use_t;

  // Effective use of the pin; audio only exists in 18-bit colour mode
  function automatic vpin_db_use_t vpin_db_use(input logic [1:0] sel, input logic m18);
    vpin_db_use_t u;
    u = VPIN_DB_BLUE1;
    if (sel == 2'h3) begin
      u = VPIN_DB_GPO5;
    end else if (sel == 2'h0 && m18) begin
      u = VPIN_DB_AUDIO;
    end
    return u;
  endfunction

endpackage

// *** core/vpin_sync3.sv ***
// Three-stage synchroniser for levels from another clock or a pin.
// The held output changes only once the second and third stages agree.
`timescale 1ns/100ps
`default_nettype none
module vpin_sync3 #(
  parameter int W = 1,
  parameter logic [W-1:0] RSTV = '0
) (
  input wire logic clk, // Destination clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic [W-1:0] d, // Asynchronous level
  output logic [W-1:0] q // Filtered synchronised level
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= RSTV;
      s2_q <= RSTV;
      s3_q <= RSTV;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Bits where the two late stages disagree keep their old value
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= RSTV;
    end else begin
      q <= (s2_q & ~(s2_q ^ s3_q)) | (q & (s2_q ^ s3_q));
    end
  end
endmodule
`default_nettype wire

// *** core/vpin_de_filter.sv ***
// Pixel-valid qualification filter on the pixel clock.
// Assumes its input is already sampled on the pixel clock.
`include "vpin_params.svh"
`timescale 1ns/100ps
`default_nettype none
module vpin_de_filter (
  input wire logic clk, // Pixel clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic filt_en, // Filter enable
  input wire logic de_in, // Sampled pixel valid
  output logic de_q // Qualified pixel valid
);
  logic [`VP_DE_CNT_W-1:0] cnt_q;

  // ----------------------------------------
  // Qualification
  // ----------------------------------------
  // Minimum pulse width
  // A level must differ for the minimum count of samples in a row;
  // shorter pulses and gaps are swallowed.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      de_q <= 1'b0;
      cnt_q <= '0;
    end else if (!filt_en) begin
      de_q <= de_in;
      cnt_q <= '0;
    end else if (de_in == de_q) begin
      cnt_q <= '0;
    end else if (cnt_q == `VP_DE_CNT_W'(`VP_DE_MIN_PCLK - 1)) begin
      de_q <= de_in;
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + `VP_DE_CNT_W'(1);
    end
  end
endmodule
`default_nettype wire

// *** core/vpin_top.sv ***
// Parallel video input stage with pin sharing, power-down and straps.
// Assumes an APB master on pclk and a video source on pix_clk; shared
// pins are split into input, output and output enable.
//
// How it works
// - With filter on, pixel-valid pulses under 3 pixel clocks are dropped.
// - With filter off, pixel-valid edges pass with no minimum width.
// - Video inputs sampled on rising or falling pixel clock edge, by select.
// - Audio clock, word clock, data pins as outputs drive output bits 8,7,6.
// - Second audio data pin is audio input only in 18-bit colour mode.
// - Second audio data pin may instead be blue bit 1 or output bit 5.
// - Four two-way GPIOs on green/red bits 1:0, only in 18-bit mode.
// - Output bits 8 to 4 come from register values on shared pins.
// - Power-down input high means normal operation.
// - Power-down low: drivers high, PLL off, control registers reset.
// - Bus target address taken from the address strap level.
// - Configuration chosen from the mode-select strap level.
`include "vpin_params.svh"
`timescale 1ns/100ps
`default_nettype none
module vpin_top
  import vpin_pkg::*;
(
  input wire logic pclk, // Register clock
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [`VP_AW-1:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic pix_clk, // Pixel clock from the video source
  input wire logic pixel_valid_in, // Pixel valid pin
  input wire logic [7:0] red_in, // Red pins
  input wire logic [7:0] green_in, // Green pins
  input wire logic [7:0] blue_in, // Blue pins
  output logic pix_valid_out, // Qualified pixel valid, pix_clk
  output logic [23:0] pix_data_out, // Sampled colour word, pix_clk
  input wire logic [2:0] aud_pin_in, // Audio clock, word clock, data pins
  output logic [2:0] aud_pin_out, // Output levels on those pins
  output logic [2:0] aud_pin_oe, // Output enables on those pins
  output logic [2:0] aud_core_out, // Audio levels to the core
  output logic aud_second_out, // Second audio channel level
  output logic [1:0] blue_lo_out, // Output levels on blue 1:0 pins
  output logic [1:0] blue_lo_oe, // Output enables on blue 1:0 pins
  output logic [3:0] gpio_out, // GPIO 3:0 output levels
  output logic [3:0] gpio_oe, // GPIO 3:0 output enables
  input wire logic powerdown_n, // Power-down pin, low powers down
  input wire logic mode_sel_strap, // Mode strap, high selects 18-bit
  input wire logic [`VP_ADDR_CODE_W-1:0] bus_address_strap, // Address strap level code
  input wire logic ser_bit, // Serial bit from the link core
  output logic ser_out_p, // Serial driver true output
  output logic ser_out_n, // Serial driver inverting output
  output logic pll_enable, // PLL run enable
  output logic [6:0] bus_target_addr // Control bus target address
);
  logic pd_n_s;
  logic strap_s;
  logic [`VP_ADDR_CODE_W-1:0] addr_s;
  logic [3:0] aud_s;
  logic [3:0] gpin_s;
  logic [1:0] de_s;
  logic [`VP_CTRL_W-1:0] ctrl_q;
  logic [`VP_GPO_HI:`VP_GPO_LO] gpo_q;
  logic [3:0] gpio_dir_q;
  logic [3:0] gpio_val_q;
  logic strap_taken_q;
  logic m18_strap_q;
  logic [`VP_DECNT_W-1:0] decnt_q;
  logic de_tog_seen_q;
  logic m18;
  vpin_db_use_t db_use;

  // ----------------------------------------
  // Pin synchronisers (pclk)
  // ----------------------------------------
  vpin_sync3 #(.W(1), .RSTV(1'b0)) u_pd_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d(powerdown_n),
    .q(pd_n_s)
  );

  vpin_sync3 #(.W(1 + `VP_ADDR_CODE_W), .RSTV('0)) u_strap_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d({mode_sel_strap, bus_address_strap}),
    .q({strap_s, addr_s})
  );

  vpin_sync3 #(.W(4), .RSTV(4'h0)) u_aud_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d({blue_in[1], aud_pin_in}),
    .q(aud_s)
  );

  vpin_sync3 #(.W(4), .RSTV(4'h0)) u_gpin_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d({green_in[1:0], red_in[1:0]}),
    .q(gpin_s)
  );

  // ----------------------------------------
  // Straps
  // ----------------------------------------
  // Straps are caught once after reset and after each power-down exit,
  // so a strap moving in normal operation does not disturb the device.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_taken_q <= 1'b0;
      m18_strap_q <= 1'b0;
      bus_target_addr <= 7'h00;
    end else if (!pd_n_s) begin
      strap_taken_q <= 1'b0;
    end else if (!strap_taken_q) begin
      strap_taken_q <= 1'b1;
      m18_strap_q <= strap_s;
      bus_target_addr <= {`VP_ADDR_BASE, addr_s};
    end
  end

  assign m18 = m18_strap_q | ctrl_q[`VP_CTRL_M18];
  assign db_use = vpin_db_use(ctrl_q[`VP_CTRL_DBSEL_HI:`VP_CTRL_DBSEL_LO], m18);

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  // Registers reset in power-down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `VP_CTRL_RST;
      gpo_q <= `VP_GPO_RST;
      gpio_dir_q <= `VP_GPIO_RST;
      gpio_val_q <= `VP_GPIO_RST;
    end else if (!pd_n_s) begin
      ctrl_q <= `VP_CTRL_RST;
      gpo_q <= `VP_GPO_RST;
      gpio_dir_q <= `VP_GPIO_RST;
      gpio_val_q <= `VP_GPIO_RST;
    end else if (psel && penable && pwrite && pready) begin
      unique case (paddr)
        `VP_OFS_CTRL: begin
          ctrl_q <= pwdata[`VP_CTRL_W-1:0];
        end
        `VP_OFS_GPO: begin
          gpo_q <= pwdata[`VP_GPO_HI:`VP_GPO_LO];
        end
        `VP_OFS_GPIO: begin
          gpio_dir_q <= pwdata[`VP_GPIO_DIR_HI:`VP_GPIO_DIR_LO];
          gpio_val_q <= pwdata[`VP_GPIO_OUT_HI:`VP_GPIO_OUT_LO];
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // APB answer
  // ----------------------------------------
  // Answer is prepared in the setup cycle, so every access has no wait.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      pready <= 1'b1;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      unique case (paddr)
        `VP_OFS_CTRL: begin
          prdata[`VP_CTRL_W-1:0] <= ctrl_q;
        end
        `VP_OFS_GPO: begin
          prdata[`VP_GPO_HI:`VP_GPO_LO] <= gpo_q;
        end
        `VP_OFS_GPIO: begin
          prdata[`VP_GPIO_DIR_HI:`VP_GPIO_DIR_LO] <= gpio_dir_q;
          prdata[`VP_GPIO_OUT_HI:`VP_GPIO_OUT_LO] <= gpio_val_q;
        end
        `VP_OFS_STAT: begin
          prdata[`VP_STAT_GPIN_HI:`VP_STAT_GPIN_LO] <= gpin_s;
          prdata[`VP_STAT_M18] <= m18;
          prdata[`VP_STAT_STRAP] <= m18_strap_q;
          prdata[`VP_STAT_DE] <= de_s[0];
          prdata[`VP_STAT_ADDR_HI:`VP_STAT_ADDR_LO] <= bus_target_addr;
        end
        `VP_OFS_DECNT: begin
          prdata[`VP_DECNT_W-1:0] <= decnt_q;
        end
        default: begin
          pslverr <= 1'b1;
        end
      endcase
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------
  // Power-down outputs
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ser_out_p <= 1'b1;
      ser_out_n <= 1'b1;
      pll_enable <= 1'b0;
    end else if (!pd_n_s) begin
      ser_out_p <= 1'b1;
      ser_out_n <= 1'b1;
      pll_enable <= 1'b0;
    end else begin
      ser_out_p <= ser_bit;
      ser_out_n <= ~ser_bit;
      pll_enable <= 1'b1;
    end
  end

  // ----------------------------------------
  // Shared audio and blue pins
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aud_pin_out <= 3'h0;
      aud_pin_oe <= 3'h0;
      aud_core_out <= 3'h0;
      aud_second_out <= 1'b0;
      blue_lo_out <= 2'h0;
      blue_lo_oe <= 2'h0;
    end else begin
      aud_pin_oe <= {3{ctrl_q[`VP_CTRL_AUDGPO]}};
      aud_pin_out <= {gpo_q[8], gpo_q[7], gpo_q[6]};
      aud_core_out <= ctrl_q[`VP_CTRL_AUDGPO] ? 3'h0 : aud_s[2:0];
      aud_second_out <= (db_use == VPIN_DB_AUDIO) ? aud_s[3] : 1'b0;
      // Blue 1 or output bit 5
      blue_lo_oe[1] <= (db_use == VPIN_DB_GPO5);
      blue_lo_out[1] <= gpo_q[5];
      // Output bit 4 on blue 0
      blue_lo_oe[0] <= ctrl_q[`VP_CTRL_B0GPO];
      blue_lo_out[0] <= gpo_q[4];
    end
  end

  // ----------------------------------------
  // GPIO on green and red bits 1:0
  // ----------------------------------------
  // GPIO only in 18-bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpio_oe <= 4'h0;
      gpio_out <= 4'h0;
    end else begin
      gpio_oe <= m18 ? gpio_dir_q : 4'h0;
      gpio_out <= gpio_val_q;
    end
  end

  // ----------------------------------------
  // Pixel valid edge counter (pclk)
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      de_tog_seen_q <= 1'b0;
      decnt_q <= '0;
    end else begin
      de_tog_seen_q <= de_s[1];
      if (de_s[1] != de_tog_seen_q) begin
        decnt_q <= decnt_q + `VP_DECNT_W'(1);
      end
    end
  end

  // ----------------------------------------
  // Pixel clock domain
  // ----------------------------------------
  logic [1:0] prst_q;
  logic pix_rst_n;
  logic [3:0] pcfg;
  logic [24:0] neg_q;
  logic [24:0] smp_q;
  logic [23:0] dly_q [`VP_DE_MIN_PCLK];
  logic de_f;
  logic de_f_d_q;
  logic de_tog_q;
  logic pm18;
  logic [1:0] pdb_code;
  vpin_db_use_t pdb_use;

  // Reset release synchronised to the pixel clock
  always_ff @(posedge pix_clk or negedge presetn) begin
    if (!presetn) begin
      prst_q <= 2'b00;
    end else begin
      prst_q <= {prst_q[0], 1'b1};
    end
  end
  assign pix_rst_n = prst_q[1];

  // Configuration is quasi-static; a change may glitch one pixel
  vpin_sync3 #(.W(4), .RSTV(4'h1)) u_cfg_sync (
    .clk(pix_clk),
    .rst_n(pix_rst_n),
    .d({m18, ctrl_q[`VP_CTRL_B0GPO], ctrl_q[`VP_CTRL_EDGE], ctrl_q[`VP_CTRL_FILT]}),
    .q(pcfg)
  );

  vpin_sync3 #(.W(2), .RSTV(2'h0)) u_db_sync (
    .clk(pix_clk),
    .rst_n(pix_rst_n),
    .d(db_use),
    .q(pdb_code)
  );
  assign pdb_use = vpin_db_use_t'(pdb_code);
  assign pm18 = pcfg[3];

  always_ff @(negedge pix_clk or negedge pix_rst_n) begin
    if (!pix_rst_n) begin
      neg_q <= '0;
    end else begin
      neg_q <= {pixel_valid_in, red_in, green_in, blue_in};
    end
  end

  always_ff @(posedge pix_clk or negedge pix_rst_n) begin
    if (!pix_rst_n) begin
      smp_q <= '0;
    end else begin
      smp_q <= pcfg[1] ? neg_q : {pixel_valid_in, red_in, green_in, blue_in};
    end
  end

  // Data is delayed to stay aligned with the filter's latency
  generate
    for (genvar i = 0; i < `VP_DE_MIN_PCLK; i++) begin : g_dly
      always_ff @(posedge pix_clk or negedge pix_rst_n) begin
        if (!pix_rst_n) begin
          dly_q[i] <= '0;
        end else begin
          dly_q[i] <= (i == 0) ? smp_q[23:0] : dly_q[(i == 0) ? 0 : i - 1];
        end
      end
    end
  endgenerate

  vpin_de_filter u_de_filter (
    .clk(pix_clk),
    .rst_n(pix_rst_n),
    .filt_en(pcfg[0]),
    .de_in(smp_q[24]),
    .de_q(de_f)
  );

  // Shared bits read as zero when their pins serve another use
  always_ff @(posedge pix_clk or negedge pix_rst_n) begin
    if (!pix_rst_n) begin
      pix_valid_out <= 1'b0;
      pix_data_out <= 24'h00_0000;
    end else begin
      pix_valid_out <= de_f;
      pix_data_out <= pcfg[0] ? dly_q[`VP_DE_MIN_PCLK - 1] : dly_q[0];
      if (pm18) begin
        pix_data_out[17:16] <= 2'h0;
        pix_data_out[9:8] <= 2'h0;
      end
      if (pdb_use != VPIN_DB_BLUE1) begin
        pix_data_out[1] <= 1'b0;
      end
      if (pcfg[2]) begin
        pix_data_out[0] <= 1'b0;
      end
    end
  end

  // Each rising edge of qualified valid is sent over as a toggle
  always_ff @(posedge pix_clk or negedge pix_rst_n) begin
    if (!pix_rst_n) begin
      de_f_d_q <= 1'b0;
      de_tog_q <= 1'b0;
    end else begin
      de_f_d_q <= de_f;
      if (de_f && !de_f_d_q) begin
        de_tog_q <= ~de_tog_q;
      end
    end
  end

  vpin_sync3 #(.W(2), .RSTV(2'h0)) u_de_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d({de_tog_q, de_f}),
    .q(de_s)
  );

endmodule
`default_nettype wire

// *** testbench/vpin_src_model.sv ***
// Video source model for the pin-sharing block: pixel valid and colour pins.
// Assumes the bench calls its tasks; pins change only after a rising pix_clk.
`timescale 1ns/100ps
`default_nettype none
module vpin_src_model (
  input wire logic pix_clk, // Pixel clock
  output logic valid, // Pixel valid pin
  output logic [23:0] col // Colour pins {red,green,blue}
);
  initial begin
    valid = 1'b0;
    col = 24'h0;
  end
  task automatic set_col(input logic [23:0] c);
    @(posedge pix_clk);
    col <= c;
  endtask
  // Pulse of n pixel clocks, then a long quiet gap
  task automatic pulse(input int n);
    @(posedge pix_clk);
    valid <= 1'b1;
    repeat (n) @(posedge pix_clk);
    valid <= 1'b0;
    // two toggles, then 130 quiet clocks
    repeat (130) @(posedge pix_clk);
  endtask
endmodule
`default_nettype wire

// *** testbench/vpin_top_sva.sv ***
// Checker for the pin-sharing top: bus answer, power-down, strap address.
// Assumes straps and power-down pin are driven as slow levels.
`include "vpin_params.svh"
`timescale 1ns/100ps
`default_nettype none
module vpin_top_sva (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic powerdown_n, // Power-down pin
  input wire logic ser_out_p, // Driver true
  input wire logic ser_out_n, // Driver inverting
  input wire logic pll_enable, // PLL run
  input wire logic [2:0] aud_pin_oe, // Audio pin enables
  input wire logic [2:0] aud_core_out, // Audio to core
  input wire logic [1:0] blue_lo_oe, // Blue pin enables
  input wire logic [3:0] gpio_oe, // GPIO enables
  input wire logic [`VP_ADDR_CODE_W-1:0] bus_address_strap, // Address strap
  input wire logic [6:0] bus_target_addr // Target address
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  // Eight cycles cover the pin synchroniser plus the output register
  sequence pd_held_s;
    (!powerdown_n)[*8];
  endsequence
  sequence run_held_s;
    powerdown_n[*8];
  endsequence
  bus_ready_a: assert property ((psel && !penable) |=> pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  pd_drive_a: assert property (pd_held_s |-> ser_out_p && ser_out_n && !pll_enable)
    else $error("drivers or PLL active in power-down");
  pd_oe_a: assert property (pd_held_s |-> aud_pin_oe == 3'h0 && blue_lo_oe == 2'h0 && gpio_oe == 4'h0)
    else $error("pin enables not reset in power-down");
  run_drive_a: assert property (run_held_s |-> pll_enable && ser_out_n == !ser_out_p)
    else $error("not in normal operation");
  strap_addr_a: assert property ((powerdown_n && $stable(bus_address_strap))[*8] |->
    bus_target_addr == {`VP_ADDR_BASE, bus_address_strap})
    else $error("target address not from strap");
  aud_group_a: assert property (aud_pin_oe != 3'h0 |-> aud_pin_oe == 3'h7)
    else $error("audio pins enabled partly");
  aud_quiet_a: assert property ((aud_pin_oe == 3'h7)[*6] |-> aud_core_out == 3'h0)
    else $error("audio input seen while pins drive");
endmodule
bind vpin_top vpin_top_sva i_vpin_top_sva (.pclk, .presetn, .psel, .penable, .pready,
  .pslverr, .powerdown_n, .ser_out_p, .ser_out_n, .pll_enable, .aud_pin_oe, .aud_core_out,
  .blue_lo_oe, .gpio_oe, .bus_address_strap, .bus_target_addr);
`default_nettype wire

// *** testbench/vpin_top_tb_top.sv ***
// Testbench for the pin-sharing top: APB register tasks and pin checks.
// Assumes the source model on pix_clk and the bound checker.
`include "vpin_params.svh"
`timescale 1ns/100ps
`default_nettype none
module vpin_top_tb_top;
  logic pclk = 1'b0;
  logic pix_clk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic powerdown_n = 1'b1;
  logic mode_sel_strap = 1'b0;
  logic ser_bit = 1'b0;
  logic [2:0] bus_address_strap = 3'h5;
  logic [2:0] aud_pin_in = 3'h5;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, pix_valid_out, aud_second_out, ser_out_p, ser_out_n, pll_enable;
  logic rerr, pvalid;
  logic [23:0] pix_data_out, col;
  logic [2:0] aud_pin_out, aud_pin_oe, aud_core_out;
  logic [1:0] blue_lo_out, blue_lo_oe;
  logic [3:0] gpio_out, gpio_oe;
  logic [6:0] bus_target_addr;
  logic [4:0] g;
  int mismatches = 0;
  int cmp_count = 0;
  int cyc = 0;
  int exp_cnt = 0;
  int pv_rise = 0;
  logic pv_q = 1'b0;
  logic [31:0] fc [5] = '{32'h01, 32'h01, 32'h01, 32'h02, 32'h02};
  int fl [5] = '{2, 3, 8, 1, 2};
  int fi [5] = '{0, 1, 1, 1, 1};
  always #4 pclk = ~pclk;
  // Offset start keeps the two clocks out of phase
  initial begin
    #3;
    forever #16 pix_clk = ~pix_clk;
  end
  vpin_top i_vpin_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pix_clk, .pixel_valid_in(pvalid), .red_in(col[23:16]),
    .green_in(col[15:8]), .blue_in(col[7:0]), .pix_valid_out, .pix_data_out, .aud_pin_in,
    .aud_pin_out, .aud_pin_oe, .aud_core_out, .aud_second_out, .blue_lo_out, .blue_lo_oe,
    .gpio_out, .gpio_oe, .powerdown_n, .mode_sel_strap, .bus_address_strap, .ser_bit,
    .ser_out_p, .ser_out_n, .pll_enable, .bus_target_addr);
  vpin_src_model i_vpin_src_model (.pix_clk, .valid(pvalid), .col);
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic final_report();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge pclk);
  endtask
  // After reset, straps are caught again only on leaving power-down
  task automatic pd_pulse();
    @(posedge pclk);
    powerdown_n <= 1'b0;
    wt(10);
    @(posedge pclk);
    powerdown_n <= 1'b1;
    wt(12);
  endtask
  // Rising edges of the qualified pixel valid, sampled mid-cycle
  always @(negedge pix_clk) begin
    pv_q <= pix_valid_out;
    if (pix_valid_out === 1'b1 && pv_q === 1'b0) begin
      pv_rise <= pv_rise + 1;
    end
  end
  // Timeout also toggles the serial bit each cycle
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    ser_bit <= ~ser_bit;
    if (cyc == 12000) begin
      mismatches++;
      final_report();
    end
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    wt(10);
    rd(`VP_OFS_CTRL, 32'(`VP_CTRL_RST));
    rd(`VP_OFS_GPO, 32'h0);
    apb(1'b1, 8'h14, 32'hff);
    chk(32'(rerr), 32'h1);
    rd(8'h14, 32'h0);
    apb(1'b0, `VP_OFS_STAT, 32'h0);
    chk(rdat & 32'h7ff0, {17'h0, `VP_ADDR_BASE, 3'h5, 8'h00});
    chk(32'(aud_core_out), 32'h5);
    for (int i = 0; i < 2; i++) begin
      g = (i == 0) ? 5'h16 : 5'h09;
      apb(1'b1, `VP_OFS_GPO, {23'h0, g, 4'h0});
      apb(1'b1, `VP_OFS_CTRL, 32'h79);
      wt(3);
      chk(32'({aud_pin_oe, aud_pin_out}), 32'({3'h7, g[4:2]}));
      chk(32'({blue_lo_oe, blue_lo_out}), 32'({2'h3, g[1:0]}));
    end
    i_vpin_src_model.set_col(24'hffffff);
    apb(1'b1, `VP_OFS_GPIO, 32'h5f);
    wt(3);
    chk(32'(gpio_oe), 32'h0);
    // 18-bit mode by register first, by strap after a power-down
    apb(1'b1, `VP_OFS_CTRL, 32'h7d);
    wt(40);
    chk(32'({gpio_oe, gpio_out}), 32'hf5);
    chk(32'(pix_data_out), 32'hfcfcfc);
    @(posedge pclk) mode_sel_strap <= 1'b1;
    pd_pulse();
    apb(1'b0, `VP_OFS_STAT, 32'h0);
    chk(rdat & 32'h30, 32'h30);
    apb(1'b1, `VP_OFS_CTRL, 32'h01);
    for (int b = 1; b >= 0; b--) begin
      i_vpin_src_model.set_col({22'h0, b[0], 1'b0});
      wt(12);
      chk(32'(aud_second_out), 32'(b[0]));
    end
    @(posedge pclk) mode_sel_strap <= 1'b0;
    pd_pulse();
    i_vpin_src_model.set_col(24'hffffff);
    wt(40);
    chk(32'(pix_data_out), 32'hffffff);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, `VP_OFS_CTRL, fc[i]);
      wt(20);
      i_vpin_src_model.pulse(fl[i]);
      exp_cnt += fi[i];
      rd(`VP_OFS_DECNT, 32'(exp_cnt));
      chk(32'(pv_rise), 32'(exp_cnt));
    end
    chk(32'(pix_data_out), 32'hffffff);
    apb(1'b1, `VP_OFS_GPO, 32'h1f0);
    @(posedge pclk);
    powerdown_n <= 1'b0;
    bus_address_strap <= 3'h2;
    wt(10);
    chk(32'({ser_out_p, ser_out_n, pll_enable}), 32'h6);
    apb(1'b1, `VP_OFS_CTRL, 32'h7f);
    @(posedge pclk) powerdown_n <= 1'b1;
    wt(12);
    chk(32'({ser_out_p ^ ser_out_n, pll_enable}), 32'h3);
    rd(`VP_OFS_CTRL, 32'(`VP_CTRL_RST));
    rd(`VP_OFS_GPO, 32'h0);
    apb(1'b0, `VP_OFS_STAT, 32'h0);
    chk(rdat & 32'h7ff0, {17'h0, `VP_ADDR_BASE, 3'h2, 8'h00});
    final_report();
  end
endmodule
`default_nettype wire
